//--- core/dmr_cfg.svh
`ifndef DMR_CFG_SVH
`define DMR_CFG_SVH
// register addresses
`define DMR_ADDR_CMD_RSVD0   16'h2400
`define DMR_ADDR_OP_CMD      16'h2401
`define DMR_ADDR_FREQ_CMD    16'h2402
`define DMR_ADDR_TORQUE_CMD  16'h2403
`define DMR_ADDR_MON_RSVD0   16'h2420
`define DMR_ADDR_OP_STATUS   16'h2421
`define DMR_ADDR_FREQ_RB     16'h2422
`define DMR_ADDR_OUT_FREQ    16'h2423
`define DMR_ADDR_OUT_CURR    16'h2424
`define DMR_ADDR_OUT_VOLT    16'h2425
`define DMR_ADDR_DC_BUS      16'h2426
`define DMR_ADDR_ALARM       16'h2427
`define DMR_ADDR_FAULT       16'h2428
`define DMR_ADDR_IO_STATUS   16'h2429
`define DMR_ADDR_AI_FIRST    16'h242a
`define DMR_ADDR_AI_SECOND   16'h242b
`define DMR_ADDR_MON_RSVD1   16'h242c
`define DMR_ADDR_AO_FIRST    16'h242d
`define DMR_ADDR_AO_SECOND   16'h242e
// operation command word fields
`define DMR_CMD_RUN_BIT      0
`define DMR_CMD_REV_BIT      1
`define DMR_CMD_EXTF_BIT     2
`define DMR_CMD_FRST_BIT     3
`define DMR_CMD_MFT_LSB      8
`define DMR_CMD_WR_MASK      16'hff0f
// status word masks
`define DMR_OPST_MASK        16'h07ff
`define DMR_IOST_MASK        16'h70ff
// reset values
`define DMR_RST_OP_CMD       16'h0000
`define DMR_RST_FREQ_CMD     16'h0000
`define DMR_RST_TORQUE_CMD   16'h0000
// scaling limits
`define DMR_TORQUE_MAX       16'sh4000
`define DMR_TORQUE_MIN       -16'sh4000
`define DMR_ALARM_MAX        5'h15
`define DMR_ANALOG_TOP       16'h03e8
`define DMR_ANALOG_BOTTOM    -16'sh03e8
`endif

//--- core/dmr_pkg.sv
`default_nettype none
package dmr_pkg;
    typedef logic [15:0] dmr_word_t;
    // alarm codes as reported in the alarm register
    typedef enum logic [4:0] {
        DMR_ALM_NONE     = 5'h00,
        DMR_ALM_SPD_DEV  = 5'h01,
        DMR_ALM_OPT_EXT  = 5'h02,
        DMR_ALM_EXT_ONE  = 5'h03,
        DMR_ALM_EXT_EIGHT= 5'h0a,
        DMR_ALM_FB_HIGH  = 5'h0b,
        DMR_ALM_FB_LOW   = 5'h0c,
        DMR_ALM_HS_OH    = 5'h0d,
        DMR_ALM_MOT_OH   = 5'h0e,
        DMR_ALM_OT_ONE   = 5'h0f,
        DMR_ALM_OT_TWO   = 5'h10,
        DMR_ALM_OV       = 5'h11,
        DMR_ALM_UV       = 5'h12,
        DMR_ALM_UT_ONE   = 5'h13,
        DMR_ALM_UT_TWO   = 5'h14,
        DMR_ALM_MECH     = 5'h15
    } dmr_alarm_e;
endpackage : dmr_pkg
`default_nettype wire

//--- core/dmr_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "dmr_cfg.svh"
module dmr_regs
(
    input  wire logic                clk_sys_i,
    input  wire logic                rst_n_i,
    input  wire logic                clk_en_i,
    // register access from the serial protocol engine
    input  wire logic [15:0]         reg_addr_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [15:0]         reg_wdata_i,
    output logic      [15:0]         reg_rdata_o,
    output logic                     reg_rvalid_o,
    output logic                     reg_err_o,
    // command outputs to drive control
    output logic                     run_cmd_o,
    output logic                     reverse_cmd_o,
    output logic                     option_external_fault_request_o,
    output logic                     fault_reset_req_o,
    output logic      [7:0]          terminal_cmd_o,
    output logic      [15:0]         freq_cmd_o,
    output logic signed [15:0]       torque_cmd_o,
    // drive state inputs
    input  wire logic                running_i,
    input  wire logic                reversing_i,
    input  wire logic                zero_hold_busy_i,
    input  wire logic                fault_present_i,
    input  wire logic                speed_agree_i,
    input  wire logic                ready_i,
    input  wire logic                freq_src_sel_i,
    input  wire logic                run_src_remote_i,
    input  wire logic                torque_mode_i,
    input  wire logic                zero_hold_active_i,
    input  wire logic [15:0]         freq_ref_i,
    input  wire logic [15:0]         output_frequency_i,
    input  wire logic [15:0]         output_current_i,
    input  wire logic [15:0]         output_voltage_i,
    input  wire logic [15:0]         dc_bus_voltage_i,
    input  wire logic [4:0]          alarm_code_i,
    input  wire logic [7:0]          fault_code_i,
    input  wire logic [7:0]          input_terminals_i,
    input  wire logic                relay_one_i,
    input  wire logic                relay_two_i,
    input  wire logic                auxiliary_input_state_i,
    input  wire logic [15:0]         analog_input_first_i,
    input  wire logic [15:0]         analog_input_second_i,
    input  wire logic signed [15:0]  analog_output_first_i,
    input  wire logic signed [15:0]  analog_output_second_i
);

    // command storage
    dmr_pkg::dmr_word_t op_cmd;
    dmr_pkg::dmr_word_t freq_cmd;
    dmr_pkg::dmr_word_t torque_cmd;

    // clamp torque to the +-200 percent span, full scale 16384
    function automatic logic [15:0] dmr_clamp_sat(input logic signed [15:0] v,
                                                  input logic signed [15:0] lo,
                                                  input logic signed [15:0] hi);
        logic signed [15:0] r;
        r = v;
        if (v > hi)
        begin
            r = hi;
        end
        else if (v < lo)
        begin
            r = lo;
        end
        return r;
    endfunction : dmr_clamp_sat

    // clamp unsigned scaled readings to their top value
    function automatic logic [15:0] dmr_clamp_top(input logic [15:0] v, input logic [15:0] top);
        return (v > top) ? top : v;
    endfunction : dmr_clamp_top

    // write decode: only the three command words accept writes
    wire wr_op     = clk_en_i & reg_wr_i & (reg_addr_i == `DMR_ADDR_OP_CMD);
    wire wr_freq   = clk_en_i & reg_wr_i & (reg_addr_i == `DMR_ADDR_FREQ_CMD);
    wire wr_torque = clk_en_i & reg_wr_i & (reg_addr_i == `DMR_ADDR_TORQUE_CMD);

    // command words; reserved bits 4..7 dropped on write
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            op_cmd     <= `DMR_RST_OP_CMD;
            freq_cmd   <= `DMR_RST_FREQ_CMD;
            torque_cmd <= `DMR_RST_TORQUE_CMD;
        end
        else
        begin
            if (wr_op)
                op_cmd <= reg_wdata_i & `DMR_CMD_WR_MASK;
            if (wr_freq)
                freq_cmd <= reg_wdata_i;
            if (wr_torque)
                torque_cmd <= dmr_clamp_sat(reg_wdata_i, `DMR_TORQUE_MIN, `DMR_TORQUE_MAX);
        end
    end

    // command fields toward drive control
    assign run_cmd_o                       = op_cmd[`DMR_CMD_RUN_BIT];
    assign reverse_cmd_o                   = op_cmd[`DMR_CMD_REV_BIT];
    assign option_external_fault_request_o = op_cmd[`DMR_CMD_EXTF_BIT];
    assign fault_reset_req_o               = op_cmd[`DMR_CMD_FRST_BIT];
    assign terminal_cmd_o                  = op_cmd[`DMR_CMD_MFT_LSB +: 8];
    assign freq_cmd_o                      = freq_cmd;
    assign torque_cmd_o                    = torque_cmd;

    // status word assembly, upper bits reserved zero
    wire [15:0] op_status = {5'h00,
                             zero_hold_active_i,
                             torque_mode_i,
                             run_src_remote_i,
                             freq_src_sel_i,
                             ready_i,
                             speed_agree_i,
                             (alarm_code_i != 5'h00),
                             fault_present_i,
                             zero_hold_busy_i,
                             reversing_i,
                             running_i};

    // io word: bits 8..11 and 15 reserved zero
    wire [15:0] io_status = {1'b0, auxiliary_input_state_i, relay_two_i, relay_one_i,
                             4'h0, input_terminals_i};

    // codes above the documented list read as no alarm in this word; the alarm bit of the status word still sets
    wire [15:0] alarm_word = (alarm_code_i > `DMR_ALARM_MAX) ? 16'h0000
                             : {11'h000, alarm_code_i};
    wire [15:0] fault_word = {8'h00, fault_code_i};

    // analog readings kept inside their documented spans
    wire [15:0] ai_first  = dmr_clamp_top(analog_input_first_i, `DMR_ANALOG_TOP);
    wire [15:0] ai_second = dmr_clamp_top(analog_input_second_i, `DMR_ANALOG_TOP);
    wire [15:0] ao_first  = dmr_clamp_sat(analog_output_first_i, `DMR_ANALOG_BOTTOM, `DMR_ANALOG_TOP);
    wire [15:0] ao_second = dmr_clamp_sat(analog_output_second_i, `DMR_ANALOG_BOTTOM, `DMR_ANALOG_TOP);

    // read mux; reserved and unmapped addresses read zero
    logic [15:0] rd_mux;
    logic        rd_hit;
    always_comb
    begin
        rd_hit = 1'b1;
        unique case (reg_addr_i)
            `DMR_ADDR_OP_CMD:     rd_mux = op_cmd;
            `DMR_ADDR_FREQ_CMD:   rd_mux = freq_cmd;
            `DMR_ADDR_TORQUE_CMD: rd_mux = torque_cmd;
            `DMR_ADDR_OP_STATUS:  rd_mux = op_status;
            `DMR_ADDR_FREQ_RB:    rd_mux = freq_ref_i;
            `DMR_ADDR_OUT_FREQ:   rd_mux = output_frequency_i;
            `DMR_ADDR_OUT_CURR:   rd_mux = output_current_i;
            `DMR_ADDR_OUT_VOLT:   rd_mux = output_voltage_i;
            `DMR_ADDR_DC_BUS:     rd_mux = dc_bus_voltage_i;
            `DMR_ADDR_ALARM:      rd_mux = alarm_word;
            `DMR_ADDR_FAULT:      rd_mux = fault_word;
            `DMR_ADDR_IO_STATUS:  rd_mux = io_status;
            `DMR_ADDR_AI_FIRST:   rd_mux = ai_first;
            `DMR_ADDR_AI_SECOND:  rd_mux = ai_second;
            `DMR_ADDR_AO_FIRST:   rd_mux = ao_first;
            `DMR_ADDR_AO_SECOND:  rd_mux = ao_second;
            `DMR_ADDR_CMD_RSVD0,
            `DMR_ADDR_MON_RSVD0,
            `DMR_ADDR_MON_RSVD1:  rd_mux = 16'h0000;
            default:
            begin
                rd_mux = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // writes to monitor or unmapped words are flagged, never stored
    wire wr_refused = reg_wr_i & ~(wr_op | wr_freq | wr_torque);

    // read data registered; one cycle latency after the request
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o  <= 16'h0000;
            reg_rvalid_o <= 1'b0;
            reg_err_o    <= 1'b0;
        end
        else if (clk_en_i)
        begin
            reg_rvalid_o <= reg_rd_i;
            reg_err_o    <= (reg_rd_i & ~rd_hit) | wr_refused;
            if (reg_rd_i)
                reg_rdata_o <= rd_mux;
        end
    end

endmodule : dmr_regs
`default_nettype wire

//--- testbench/dmr_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module dmr_regs_assertions
(
    input wire logic               clk_sys_i,
    input wire logic               rst_n_i,
    input wire logic               clk_en_i,
    input wire logic [15:0]        reg_addr_i,
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire logic [15:0]        reg_wdata_i,
    input wire logic [15:0]        reg_rdata_o,
    input wire logic               reg_rvalid_o,
    input wire logic               reg_err_o,
    input wire logic               run_cmd_o,
    input wire logic [7:0]         terminal_cmd_o,
    input wire logic signed [15:0] torque_cmd_o,
    input wire logic [7:0]         fault_code_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // request shapes as taken at a rising edge
    sequence s_rd(a);
        clk_en_i && reg_rd_i && reg_addr_i == a;
    endsequence
    sequence s_wr(a);
        clk_en_i && reg_wr_i && reg_addr_i == a;
    endsequence
    a_read_answer: assert property (clk_en_i && reg_rd_i |=> reg_rvalid_o) else $error("no read answer");
    a_idle_quiet: assert property (clk_en_i && !reg_rd_i |=> !reg_rvalid_o) else $error("stray rvalid");
    a_rdata_holds: assert property (clk_en_i && !reg_rd_i |=> $stable(reg_rdata_o)) else $error("rdata moved");
    a_run_follows: assert property (s_wr(16'h2401) |=> run_cmd_o == $past(reg_wdata_i[0]))
        else $error("run bit wrong");
    a_term_follows: assert property (s_wr(16'h2401) |=> terminal_cmd_o == $past(reg_wdata_i[15:8]))
        else $error("terminals wrong");
    a_torque_clamp: assert property (s_wr(16'h2403) ##0 $signed(reg_wdata_i) > 16'sh4000
        |=> torque_cmd_o == 16'sh4000) else $error("torque not clamped");
    a_write_refused: assert property (clk_en_i && reg_wr_i && (reg_addr_i < 16'h2401 || reg_addr_i > 16'h2403)
        |=> reg_err_o) else $error("refused write no error");
    a_fault_read: assert property (s_rd(16'h2428) |=> reg_rdata_o == {8'h00, $past(fault_code_i)})
        else $error("fault code wrong");
    a_rsvd_zero: assert property (s_rd(16'h2420) |=> reg_rdata_o == 16'h0000) else $error("reserved not zero");
endmodule : dmr_regs_assertions
bind dmr_regs dmr_regs_assertions u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .reg_err_o(reg_err_o), .run_cmd_o(run_cmd_o),
    .terminal_cmd_o(terminal_cmd_o), .torque_cmd_o(torque_cmd_o), .fault_code_i(fault_code_i));
`default_nettype wire

//--- testbench/dmr_master_model.sv
`timescale 1ns/1ns
`default_nettype none
// master side of the register link, one word per call
module dmr_master_model
(
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] rdata_i,
    input  wire logic        err_i,
    output logic      [15:0] addr_o,
    output logic      [15:0] wdata_o,
    output logic             wr_o,
    output logic             rd_o
);
    initial
    begin
        addr_o = 16'h0000;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // request held across one rising edge, answer taken one cycle later
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic e);
        @(negedge clk_sys_i);
        addr_o = a;
        wdata_o = d;
        wr_o = w;
        rd_o = !w;
        @(negedge clk_sys_i);
        q = rdata_i;
        e = err_i;
        // released lines show junk so nothing leans on stale values
        addr_o = ~a;
        wdata_o = ~d;
        wr_o = 1'b0;
        rd_o = 1'b0;
    endtask : xfer
endmodule : dmr_master_model
`default_nettype wire

//--- testbench/drive_modbus_data_registers_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, x, g) begin num_checks++; if ((x) !== (g)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", n, x, g); end end
module drive_modbus_data_registers_tb_top;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [10:0] st = 11'h000;
    logic [4:0]  alm = 5'h00;
    logic [7:0]  flt = 8'h00;
    logic [7:0]  inp = 8'h00;
    logic [2:0]  rly = 3'h0;
    logic [15:0] mon [0:8] = '{default: 16'h0000};
    logic [15:0] addr, wdata, rdata, freq;
    logic        wr, rd, err, rvalid, run, rev, extf, frst;
    logic        ce = 1'b1;
    logic [7:0]  term;
    logic signed [15:0] trq;
    int          fail_count = 0;
    int          num_checks = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    dmr_master_model mst (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .err_i(err), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    // clock enable driven by the bench so a frozen write is judged too
    dmr_regs dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(ce), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_err_o(err),
        .run_cmd_o(run), .reverse_cmd_o(rev), .option_external_fault_request_o(extf), .fault_reset_req_o(frst),
        .terminal_cmd_o(term), .freq_cmd_o(freq), .torque_cmd_o(trq), .running_i(st[0]), .reversing_i(st[1]),
        .zero_hold_busy_i(st[2]), .fault_present_i(st[3]), .speed_agree_i(st[5]), .ready_i(st[6]),
        .freq_src_sel_i(st[7]), .run_src_remote_i(st[8]), .torque_mode_i(st[9]), .zero_hold_active_i(st[10]),
        .freq_ref_i(mon[0]), .output_frequency_i(mon[1]), .output_current_i(mon[2]), .output_voltage_i(mon[3]),
        .dc_bus_voltage_i(mon[4]), .alarm_code_i(alm), .fault_code_i(flt), .input_terminals_i(inp),
        .relay_one_i(rly[0]), .relay_two_i(rly[1]), .auxiliary_input_state_i(rly[2]),
        .analog_input_first_i(mon[5]), .analog_input_second_i(mon[6]), .analog_output_first_i(mon[7]),
        .analog_output_second_i(mon[8]));
    // one bus word with its read value and error flag judged
    task automatic acc(input string n, input logic w, input logic [15:0] a, d, x, input logic xe);
        logic [15:0] q;
        logic        e;
        mst.xfer(w, a, d, q, e);
        if (!w) `CHK(n, x, q)
        `CHK({n, " err"}, xe, e)
        `CHK({n, " vld"}, (!w && ce), rvalid)
    endtask : acc
    task automatic t_cmd;
        logic [15:0] tw [0:4] = '{16'h4000, 16'hc000, 16'h7fff, 16'h8000, 16'h0123};
        logic [15:0] tx [0:4] = '{16'h4000, 16'hc000, 16'h4000, 16'hc000, 16'h0123};
        for (int a = 1; a < 4; a++) acc("cmd reset", 0, 16'h2400 + a, 16'h0000, 16'h0000, 0);
        acc("op", 1, 16'h2401, 16'ha5ff, 16'h0000, 0);
        `CHK("op outs", 12'ha5f, {term, frst, extf, rev, run})
        acc("op", 0, 16'h2401, 16'h0000, 16'ha50f, 0);
        acc("op", 1, 16'h2401, 16'h0102, 16'h0000, 0);
        `CHK("op outs", 12'h012, {term, frst, extf, rev, run})
        acc("freq", 1, 16'h2402, 16'h1770, 16'h0000, 0);
        `CHK("freq", 16'h1770, freq)
        for (int i = 0; i < 5; i++)
        begin
            acc("torque", 1, 16'h2403, tw[i], 16'h0000, 0);
            `CHK("torque", tx[i], trq)
        end
        $display("t_cmd done");
    endtask : t_cmd
    // clock enable low: a write must leave no trace and raise no answer
    task automatic t_freeze;
        @(negedge clk_sys_i);
        ce = 1'b0;
        acc("frozen wr", 1, 16'h2401, 16'hffff, 16'h0000, 0);
        `CHK("frozen outs", 12'h012, {term, frst, extf, rev, run})
        ce = 1'b1;
        acc("thawed", 0, 16'h2401, 16'h0000, 16'h0102, 0);
        $display("t_freeze done");
    endtask : t_freeze
    task automatic t_status;
        for (int i = 0; i < 11; i++)
        begin
            st = 11'h001 << i;
            alm = (i == 4) ? 5'h01 : 5'h00;
            acc("status", 0, 16'h2421, 16'h0000, 16'h0001 << i, 0);
        end
        st = 11'h000;
        for (int j = 0; j < 32; j++)
        begin
            alm = j[4:0];
            acc("alarm", 0, 16'h2427, 16'h0000, (j < 22) ? j[15:0] : 16'h0000, 0);
        end
        alm = 5'h00;
        $display("t_status done");
    endtask : t_status
    task automatic t_monitor;
        logic [15:0] v [0:8] = '{16'h1770, 16'h1388, 16'h00c8, 16'h0dc0, 16'h0c80, 16'h03e8, 16'h0200,
                                 16'hfc18, 16'h03e8};
        for (int k = 0; k < 9; k++)
        begin
            mon[k] = v[k];
            acc("monitor", 0, (k < 5) ? 16'h2422 + k : (k < 7) ? 16'h2425 + k : 16'h2426 + k, 16'h0000, v[k],
                0);
        end
        mon[5] = 16'h0400;
        mon[7] = 16'h8000;
        acc("ai clamp", 0, 16'h242a, 16'h0000, 16'h03e8, 0);
        acc("ao clamp", 0, 16'h242d, 16'h0000, 16'hfc18, 0);
        inp = 8'h5a;
        rly = 3'h7;
        acc("io", 0, 16'h2429, 16'h0000, 16'h705a, 0);
        flt = 8'h2a;
        acc("fault", 0, 16'h2428, 16'h0000, 16'h002a, 0);
        $display("t_monitor done");
    endtask : t_monitor
    task automatic t_refuse;
        acc("ro wr", 1, 16'h2421, 16'hffff, 16'h0000, 1);
        acc("rsvd wr", 1, 16'h2400, 16'hffff, 16'h0000, 1);
        acc("op kept", 0, 16'h2401, 16'h0000, 16'h0102, 0);
        acc("rsvd", 0, 16'h2400, 16'h0000, 16'h0000, 0);
        acc("rsvd", 0, 16'h2420, 16'h0000, 16'h0000, 0);
        acc("rsvd", 0, 16'h242c, 16'h0000, 16'h0000, 0);
        acc("unmapped", 0, 16'h2430, 16'h0000, 16'h0000, 1);
        $display("t_refuse done");
    endtask : t_refuse
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        t_cmd;
        t_freeze;
        t_status;
        t_monitor;
        t_refuse;
        summarize;
    end
    // about 80 transfers of two cycles each; far more than enough
    initial
    begin
        #200000;
        fail_count++;
        summarize;
    end
endmodule : drive_modbus_data_registers_tb_top
`default_nettype wire
